// file: verilog/pwr_seq_pkg.sv
package pwr_seq_pkg;

    // ************************************************************
    // Timing constants.
    // ************************************************************
    localparam int unsigned CLK_FREQ_HZ      = 40_000_000;
    localparam int unsigned HW_DEGLITCH_US   = 5000;
    localparam int unsigned HW_DEGLITCH_CYC  =
        (HW_DEGLITCH_US * (CLK_FREQ_HZ / 1_000_000));
    localparam int unsigned RESET_K_US_PER_NF = 1000;
    localparam int unsigned RESET_CAP_NF     = 100;
    localparam int unsigned RESET_TIMER_CYC  =
        (RESET_K_US_PER_NF * RESET_CAP_NF * (CLK_FREQ_HZ / 1_000_000));
    localparam int unsigned PGOOD_CHECK_CYC  = 16;

    // ************************************************************
    // Field positions and reset values.
    // ************************************************************
    localparam int unsigned SUPPLY_COUNT     = 8;
    localparam int unsigned CTRL_SOFT_RST_BIT = 0;
    localparam int unsigned CTRL_SLEEP_BIT   = 6;
    localparam logic [7:0]  FAULT_MASK_RESET = 8'hFF;

    // ************************************************************
    // Operating modes.
    // ************************************************************
    typedef enum logic [5:0] {
        ST_NO_POWER = 6'h01,
        ST_ENABLE   = 6'h02,
        ST_RESET    = 6'h04,
        ST_PG_CHECK = 6'h08,
        ST_NORMAL   = 6'h10,
        ST_SLEEP    = 6'h20
    } mode_e;

    // Cause recorded when sleep is entered.
    typedef enum logic [1:0] {
        SLP_THERMAL = 2'h0,
        SLP_LOW_SYS = 2'h1,
        SLP_SOFT    = 2'h2,
        SLP_PGOOD   = 2'h3
    } sleep_cause_e;

endpackage

// file: verilog/power_mode_sequencer.sv
`timescale 1ns/1ps
// Summary of operation
// R1: Host reset output is driven low throughout the reset state.
// R2: Reset state length is timer constant times capacitance, 1 ms per nF.
// R3: Serial slave engine held in reset while host reset output is low.
// R4: Comparators ignored in reset; timer expiry moves to power-good check.
// R5: Interrupt output falls high to low when reset state ends; the code sets it high only in enable, not on soft or hardware reset.
// R6: Check state enables comparators; below 90 percent flags a fault.
// R7: After check, unmasked fault goes to sleep, otherwise normal.
// R8: Masked supplies raise no fault but their status still reports it.
// R9: All fault mask bits come up masked at power up.
// R10: In normal, thermal or low system voltage sleeps; pgood fault powers off.
// R11: Software reset bit zero in normal enters the reset state.
// R12: Software sleep bit six in normal enters sleep.
// R13: Hardware reset low past 5 ms drops host reset; reset starts on release.
// R14: Hardware or software reset leaves register contents unchanged.
// R15: Sleep entry drops host reset and restores listed control defaults.
// R16: Sleep disables sequencing and supplies; backup regulator per enable bit.
// R17: Leaving sleep sequences supplies from the restored default values.
// R18: Thermal sleep only leaves on undervoltage lockout, to no power.
// R19: Low voltage or soft sleep, battery only: input power goes to enable.
// R20: Sleep with both sources: remove all, reconnect one, goes to enable.
// R21: Standby by bit or pin puts both bucks in pulse mode at standby volts.
// R22: Host must not use the serial lines until host reset output is high.
// R23: Defaults-loaded flag is cleared whenever power-up defaults are loaded.
// R24: Any unmasked status bit change counts as a power-good fault event.
// R25: Reset timer is a counter with a parameter terminal count.
module power_mode_sequencer
    import pwr_seq_pkg::*;
#(
    parameter int unsigned RESET_CYCLES   = pwr_seq_pkg::RESET_TIMER_CYC,
    parameter int unsigned DEGLITCH_CYCLES = pwr_seq_pkg::HW_DEGLITCH_CYC
) (
    // Clock and reset.
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    // External pins.
    input  wire logic        hw_reset_request_n_i,
    input  wire logic        uvlo_i,
    input  wire logic        ac_present_i,
    input  wire logic        usb_present_i,
    input  wire logic        bat_present_i,
    input  wire logic        sys_low_i,
    input  wire logic        thermal_fault_i,
    input  wire logic        standby_pin_i,
    // Supply comparators, one bit per supply, high when below 90 percent.
    input  wire logic [7:0]  supply_below_i,
    // Software control bits.
    input  wire logic        soft_reset_i,
    input  wire logic        soft_sleep_i,
    input  wire logic        standby_bit_i,
    input  wire logic        mask_we_i,
    input  wire logic [7:0]  mask_wdata_i,
    input  wire logic        flag_set_i,
    input  wire logic        backup_enable_i,
    // Host-facing outputs.
    output logic             host_reset_out_n_o,
    output logic             int_n_o,
    output logic             i2c_engine_reset_o,
    // Status and control outputs.
    output logic [5:0]       mode_o,
    output logic [7:0]       supply_status_o,
    output logic [7:0]       supply_fault_mask_reg_o,
    output logic             defaults_loaded_flag_n_o,
    output logic             restore_defaults_o,
    output logic             comparators_en_o,
    output logic             sequencing_en_o,
    output logic             supplies_off_o,
    output logic             backup_regulator_on_o,
    output logic             buck_standby_o
);
    import pwr_seq_pkg::*;

    // ************************************************************
    // Pin input synchronisers.
    // ************************************************************
    localparam int unsigned NPIN = 8;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] sync1;
    logic [NPIN-1:0] sync2;
    logic [NPIN-1:0] sync3;
    logic [NPIN-1:0] pin_q;

    assign pin_raw = {standby_pin_i, thermal_fault_i, sys_low_i,
                      bat_present_i, usb_present_i, ac_present_i,
                      uvlo_i, hw_reset_request_n_i};

    // Three stages; a level is accepted once stages two and three agree.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1 <= 8'h01;
            sync2 <= 8'h01;
            sync3 <= 8'h01;
            pin_q <= 8'h01;
        end else begin
            sync1 <= pin_raw;
            sync2 <= sync1;
            sync3 <= sync2;
            pin_q <= (sync2 & sync3) | (pin_q & (sync2 ^ sync3));
        end
    end

    logic hw_req_n;
    logic uvlo;
    logic input_pwr;
    logic bat;
    logic sys_low;
    logic thermal;
    logic standby_pin;
    assign hw_req_n    = pin_q[0];
    assign uvlo        = pin_q[1];
    assign input_pwr   = pin_q[2] | pin_q[3];
    assign bat         = pin_q[4];
    assign sys_low     = pin_q[5];
    assign thermal     = pin_q[6];
    assign standby_pin = pin_q[7];

    // Comparator bus, synchronised the same way.
    logic [7:0] cmp1;
    logic [7:0] cmp2;
    logic [7:0] cmp3;
    logic [7:0] cmp_q;
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cmp1  <= 8'h00;
            cmp2  <= 8'h00;
            cmp3  <= 8'h00;
            cmp_q <= 8'h00;
        end else begin
            cmp1  <= supply_below_i;
            cmp2  <= cmp1;
            cmp3  <= cmp2;
            cmp_q <= (cmp2 & cmp3) | (cmp_q & (cmp2 ^ cmp3));
        end
    end

    // ************************************************************
    // State and counters.
    // ************************************************************
    mode_e        state;
    mode_e        next_state;
    sleep_cause_e cause;
    logic [31:0]  timer;
    logic [31:0]  dgl_cnt;
    logic         hw_held;
    logic         inputs_gone;
    logic         pg_fault;

    // ************************************************************
    // Decoding helpers.
    // ************************************************************
    // True in the modes where the host runs and the monitors watch.
    function automatic logic is_host_mode(input mode_e m);
        return m == ST_PG_CHECK || m == ST_NORMAL;
    endfunction

    // True on the cycle that carries the machine into sleep.
    function automatic logic is_sleep_entry(input mode_e cur,
                                            input mode_e nxt);
        return cur != ST_SLEEP && nxt == ST_SLEEP;
    endfunction

    // Hardware reset deglitch: count low time, latch when it passes.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dgl_cnt <= 32'h0;
            hw_held <= 1'b0;
        end else if (hw_req_n) begin
            dgl_cnt <= 32'h0;
            hw_held <= 1'b0;
        end else if (state == ST_NORMAL || hw_held) begin
            if (dgl_cnt >= DEGLITCH_CYCLES)
                hw_held <= 1'b1; // [R13]
            else
                dgl_cnt <= dgl_cnt + 32'h1;
        end
    end

    // Fault mask: reset to all masked, written by software only.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            supply_fault_mask_reg_o <= FAULT_MASK_RESET; // [R9]
        else if (mask_we_i)
            supply_fault_mask_reg_o <= mask_wdata_i; // [R14]
    end

    // Status register follows the comparators only while they run.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            supply_status_o <= 8'h00;
        else if (comparators_en_o)
            supply_status_o <= cmp_q; // [R6] [R8]
    end

    // Fault: an unmasked bit that is set; in normal, an unmasked bit that toggles.
    always_comb begin
        pg_fault = |(cmp_q & ~supply_fault_mask_reg_o); // [R7] [R8]
        if (state == ST_NORMAL)
            pg_fault = |((cmp_q ^ supply_status_o)
                         & ~supply_fault_mask_reg_o); // [R24]
    end

    // Next-state decision.
    always_comb begin
        next_state = state;
        unique case (state)
            ST_NO_POWER: begin
                if (!uvlo && (input_pwr || bat))
                    next_state = ST_ENABLE;
            end
            ST_ENABLE: begin
                if (!sys_low)
                    next_state = ST_RESET;
            end
            ST_RESET: begin
                if (timer >= RESET_CYCLES - 1)
                    next_state = ST_PG_CHECK; // [R2] [R4] [R25]
            end
            ST_PG_CHECK: begin
                if (timer >= PGOOD_CHECK_CYC - 1)
                    next_state = pg_fault ? ST_SLEEP : ST_NORMAL; // [R7]
            end
            ST_NORMAL: begin
                if (thermal || sys_low)
                    next_state = ST_SLEEP; // [R10]
                else if (pg_fault)
                    next_state = ST_NO_POWER; // [R10]
                else if (hw_held && hw_req_n)
                    next_state = ST_RESET; // [R13]
                else if (soft_reset_i)
                    next_state = ST_RESET; // [R11]
                else if (soft_sleep_i)
                    next_state = ST_SLEEP; // [R12]
            end
            ST_SLEEP: begin
                if (uvlo)
                    next_state = ST_NO_POWER; // [R18]
                else if (cause == SLP_THERMAL)
                    next_state = ST_SLEEP; // [R18]
                else if (inputs_gone && input_pwr)
                    next_state = ST_ENABLE; // [R19] [R20]
            end
        endcase
    end

    // Every move goes through next_state, so the timer and the outputs
    // always follow the same decision as the state itself.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            state <= ST_NO_POWER;
        else
            state <= next_state;
    end

    // Shared timer for the reset and check states.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            timer <= 32'h0;
        else if (next_state != state)
            timer <= 32'h0;
        else
            timer <= timer + 32'h1; // [R25]
    end

    // Sleep cause and input removal tracking.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cause       <= SLP_SOFT;
            inputs_gone <= 1'b0;
        end else if (is_sleep_entry(state, next_state)) begin
            if (state == ST_PG_CHECK)
                cause <= SLP_PGOOD;
            else if (thermal)
                cause <= SLP_THERMAL;
            else if (sys_low)
                cause <= SLP_LOW_SYS;
            else
                cause <= SLP_SOFT;
            inputs_gone <= !input_pwr; // [R19]
        end else if (state == ST_SLEEP && !input_pwr) begin
            inputs_gone <= 1'b1; // [R20]
        end
    end

    // ************************************************************
    // Outputs.
    // ************************************************************
    // The host runs only in check and normal, and not while a latched
    // hardware reset request is still held low.
    logic host_run;
    assign host_run = is_host_mode(next_state) && !(hw_held && !hw_req_n);

    // Host reset, serial engine reset and interrupt.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            host_reset_out_n_o <= 1'b0;
            i2c_engine_reset_o <= 1'b1;
            int_n_o            <= 1'b1;
        end else begin
            host_reset_out_n_o <= host_run; // [R1] [R15]
            i2c_engine_reset_o <= !host_run; // [R3]
            if (state == ST_RESET && next_state == ST_PG_CHECK)
                int_n_o <= 1'b0; // [R5]
            else if (next_state == ST_ENABLE)
                int_n_o <= 1'b1;
        end
    end

    // Mode flags and power control.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_o                <= ST_NO_POWER;
            comparators_en_o      <= 1'b0;
            sequencing_en_o       <= 1'b0;
            supplies_off_o        <= 1'b1;
            backup_regulator_on_o <= 1'b0;
            restore_defaults_o    <= 1'b0;
            buck_standby_o        <= 1'b0;
        end else begin
            mode_o           <= next_state;
            comparators_en_o <= is_host_mode(next_state); // [R4] [R6]
            sequencing_en_o  <= next_state == ST_ENABLE; // [R17]
            supplies_off_o   <= next_state == ST_SLEEP
                                || next_state == ST_NO_POWER; // [R16]
            backup_regulator_on_o <= next_state != ST_NO_POWER
                                     && (next_state != ST_SLEEP
                                         || backup_enable_i); // [R16]
            restore_defaults_o <= is_sleep_entry(state, next_state); // [R15]
            buck_standby_o   <= next_state == ST_NORMAL
                                && (standby_bit_i || standby_pin); // [R21]
        end
    end

    // Defaults-loaded flag: cleared on default load, set by the host.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            defaults_loaded_flag_n_o <= 1'b0; // [R23]
        else if (next_state == ST_NO_POWER
                 || is_sleep_entry(state, next_state))
            defaults_loaded_flag_n_o <= 1'b0; // [R23]
        else if (flag_set_i)
            defaults_loaded_flag_n_o <= 1'b1;
    end

endmodule // power_mode_sequencer

// file: verif/host_model.sv
`timescale 1ns/1ps
// ********
// Host side: turns bench commands into control bit writes.
// ********
module host_model (
    // Clock and reset.
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    // Bench command and reset from the device.
    input  wire logic [1:0] cmd_i,
    input  wire logic       host_reset_out_n_i,
    // Control bits toward the device.
    output logic            soft_reset_o,
    output logic            soft_sleep_o
);
    // A write goes out only while the host is out of reset.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            soft_reset_o <= 1'b0;
            soft_sleep_o <= 1'b0;
        end else begin
            soft_reset_o <= host_reset_out_n_i && cmd_i == 2'h1;
            soft_sleep_o <= host_reset_out_n_i && cmd_i == 2'h2;
        end
    end
endmodule // host_model

// file: verif/power_mode_sequencer_assertions.sv
`timescale 1ns/1ps
// ********
// Mode sequencing checks.
// ********
module power_mode_sequencer_checker
    import pwr_seq_pkg::*;
#(
    parameter int unsigned RESET_CYCLES = pwr_seq_pkg::RESET_TIMER_CYC
) (
    input wire logic       mclk_i,
    input wire logic       rst_n_i,
    input wire logic       backup_enable_i,
    input wire logic       mask_we_i,
    input wire logic       host_reset_out_n_o,
    input wire logic       int_n_o,
    input wire logic       i2c_engine_reset_o,
    input wire logic [5:0] mode_o,
    input wire logic [7:0] supply_status_o,
    input wire logic [7:0] supply_fault_mask_reg_o,
    input wire logic       restore_defaults_o,
    input wire logic       sequencing_en_o,
    input wire logic       supplies_off_o,
    input wire logic       backup_regulator_on_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    int unsigned rst_len;

    // Counts the cycles spent in the reset state.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_len <= 0;
        end else begin
            rst_len <= (mode_o == ST_RESET) ? rst_len + 1 : 0;
        end
    end

    // Steps out of the reset and check states.
    sequence reset_end_s;
        mode_o == ST_RESET ##1 mode_o == ST_PG_CHECK;
    endsequence
    sequence check_pass_s;
        mode_o == ST_PG_CHECK ##1 mode_o == ST_NORMAL;
    endsequence

    engine_hold_a: assert property (
        i2c_engine_reset_o == !host_reset_out_n_o) else $error("engine");
    host_low_a: assert property (mode_o == ST_RESET |->
        !host_reset_out_n_o) else $error("host reset high in reset");
    reset_length_a: assert property (reset_end_s |->
        rst_len + 1 >= RESET_CYCLES && rst_len <= RESET_CYCLES + 1)
        else $error("reset length");
    int_raise_a: assert property (reset_end_s |-> ##[0:2] !int_n_o)
        else $error("no interrupt");
    clean_normal_a: assert property (check_pass_s |->
        (supply_status_o & ~supply_fault_mask_reg_o) == 8'h00)
        else $error("normal with fault");
    sleep_state_a: assert property (
        mode_o == ST_SLEEP && $past(mode_o) == ST_SLEEP |->
        !host_reset_out_n_o && supplies_off_o && !sequencing_en_o)
        else $error("sleep outputs");
    backup_a: assert property (mode_o == ST_SLEEP &&
        $past(mode_o) == ST_SLEEP && $stable(backup_enable_i) |->
        backup_regulator_on_o == backup_enable_i) else $error("backup");
    restore_a: assert property ($rose(restore_defaults_o) |=>
        !restore_defaults_o && mode_o == ST_SLEEP) else $error("restore");
    regs_kept_a: assert property ($past(mode_o) == ST_NORMAL &&
        mode_o == ST_RESET && !$past(mask_we_i) |->
        $stable(supply_fault_mask_reg_o)) else $error("mask changed");
endmodule // power_mode_sequencer_checker

bind power_mode_sequencer power_mode_sequencer_checker #(
    .RESET_CYCLES(RESET_CYCLES)
) chk_u (.mclk_i, .rst_n_i, .backup_enable_i, .mask_we_i,
    .host_reset_out_n_o, .int_n_o, .i2c_engine_reset_o, .mode_o,
    .supply_status_o, .supply_fault_mask_reg_o, .restore_defaults_o,
    .sequencing_en_o, .supplies_off_o, .backup_regulator_on_o);

// file: verif/power_mode_sequencer_test.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
    $display("mismatch %s exp %0h got %0h", n, e, g); end end
module power_mode_sequencer_test;
    import pwr_seq_pkg::*;
    localparam int unsigned RCYC = 20;
    localparam int unsigned DCYC = 10;
    int fails = 0, checked = 0, cyc = 0;
    logic mclk_i = 1'b0, rst_n_i = 1'b0, hw_reset_request_n_i = 1'b1;
    logic uvlo_i = 1'b1, ac_present_i = 1'b0, bat_present_i = 1'b1;
    logic sys_low_i = 1'b0, thermal_fault_i = 1'b0, standby_bit_i = 1'b0;
    logic mask_we_i = 1'b0, flag_set_i = 1'b0, backup_enable_i = 1'b1;
    logic [7:0] supply_below_i = 8'h00, mask_wdata_i = 8'h00;
    logic [1:0] cmd = 2'h0;
    logic soft_reset_i, soft_sleep_i, host_reset_out_n_o, int_n_o;
    logic i2c_engine_reset_o, defaults_loaded_flag_n_o, restore_defaults_o;
    logic comparators_en_o, sequencing_en_o, supplies_off_o;
    logic backup_regulator_on_o, buck_standby_o;
    logic [5:0] mode_o;
    logic [7:0] supply_status_o, supply_fault_mask_reg_o;

    // Device under test and the host beside it.
    power_mode_sequencer #(.RESET_CYCLES(RCYC), .DEGLITCH_CYCLES(DCYC))
    dut_u (.mclk_i, .rst_n_i, .hw_reset_request_n_i, .uvlo_i,
        .ac_present_i, .usb_present_i(1'b0), .bat_present_i, .sys_low_i,
        .thermal_fault_i, .standby_pin_i(1'b0), .supply_below_i,
        .soft_reset_i, .soft_sleep_i, .standby_bit_i, .mask_we_i,
        .mask_wdata_i, .flag_set_i, .backup_enable_i, .host_reset_out_n_o,
        .int_n_o, .i2c_engine_reset_o, .mode_o, .supply_status_o,
        .supply_fault_mask_reg_o, .defaults_loaded_flag_n_o,
        .restore_defaults_o, .comparators_en_o, .sequencing_en_o,
        .supplies_off_o, .backup_regulator_on_o, .buck_standby_o);
    host_model host_u (.mclk_i, .rst_n_i, .cmd_i(cmd),
        .host_reset_out_n_i(host_reset_out_n_o),
        .soft_reset_o(soft_reset_i), .soft_sleep_o(soft_sleep_i));

    // Clock and hang guard.
    always #12.5 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            test_done();
        end
    end

    // Waits a bounded time for a mode, then compares it.
    task automatic wm(input logic [5:0] m);
        int n = 0;
        while (mode_o !== m && n < 200) begin
            @(posedge mclk_i);
            #1;
            n++;
        end
        `CHK("mode", m, mode_o)
    endtask

    // Runs reset and check, expecting the given mode afterwards.
    task automatic up(input logic [5:0] m);
        wm(ST_RESET);
        `CHK("host reset", 1'b0, host_reset_out_n_o)
        `CHK("engine reset", 1'b1, i2c_engine_reset_o)
        `CHK("cmp off", 1'b0, comparators_en_o)
        wm(ST_PG_CHECK);
        `CHK("int", 1'b0, int_n_o)
        `CHK("cmp on", 1'b1, comparators_en_o)
        wm(m);
    endtask

    // Host command pulse through the partner.
    task automatic host(input logic [1:0] c);
        @(posedge mclk_i);
        cmd <= c;
        @(posedge mclk_i);
        cmd <= 2'h0;
    endtask

    task automatic test_done();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Main sequence of mode transitions.
    initial begin
        repeat (16) @(posedge mclk_i);
        #1;
        `CHK("mode", ST_NO_POWER, mode_o)
        `CHK("mask", 8'hFF, supply_fault_mask_reg_o)
        `CHK("flag", 1'b0, defaults_loaded_flag_n_o)
        @(posedge mclk_i);
        rst_n_i <= 1'b1;
        uvlo_i <= 1'b0;
        supply_below_i <= 8'h81;
        up(ST_NORMAL);
        `CHK("status", 8'h81, supply_status_o)
        @(posedge mclk_i);
        flag_set_i <= 1'b1;
        mask_we_i <= 1'b1;
        mask_wdata_i <= 8'h7E;
        @(posedge mclk_i);
        flag_set_i <= 1'b0;
        mask_we_i <= 1'b0;
        host(2'h1);
        wm(ST_RESET);
        `CHK("mask", 8'h7E, supply_fault_mask_reg_o)
        `CHK("flag", 1'b1, defaults_loaded_flag_n_o)
        wm(ST_SLEEP);
        `CHK("restore", 1'b1, restore_defaults_o)
        `CHK("off", 1'b1, supplies_off_o)
        `CHK("backup", 1'b1, backup_regulator_on_o)
        `CHK("flag", 1'b0, defaults_loaded_flag_n_o)
        host(2'h1);
        repeat (8) @(posedge mclk_i);
        supply_below_i <= 8'h00;
        ac_present_i <= 1'b1;
        `CHK("mode", ST_SLEEP, mode_o)
        wm(ST_ENABLE);
        `CHK("seq", 1'b1, sequencing_en_o)
        up(ST_NORMAL);
        supply_below_i <= 8'h01;
        wm(ST_NO_POWER);
        supply_below_i <= 8'h00;
        up(ST_NORMAL);
        hw_reset_request_n_i <= 1'b0;
        repeat (DCYC + 8) @(posedge mclk_i);
        hw_reset_request_n_i <= 1'b1;
        #1;
        `CHK("host reset", 1'b0, host_reset_out_n_o)
        `CHK("mode", ST_NORMAL, mode_o)
        up(ST_NORMAL);
        standby_bit_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        standby_bit_i <= 1'b0;
        #1;
        `CHK("standby", 1'b1, buck_standby_o)
        host(2'h2);
        wm(ST_SLEEP);
        ac_present_i <= 1'b0;
        repeat (8) @(posedge mclk_i);
        ac_present_i <= 1'b1;
        `CHK("mode", ST_SLEEP, mode_o)
        wm(ST_ENABLE);
        `CHK("seq", 1'b1, sequencing_en_o)
        up(ST_NORMAL);
        thermal_fault_i <= 1'b1;
        backup_enable_i <= 1'b0;
        wm(ST_SLEEP);
        ac_present_i <= 1'b0;
        repeat (8) @(posedge mclk_i);
        ac_present_i <= 1'b1;
        repeat (8) @(posedge mclk_i);
        uvlo_i <= 1'b1;
        `CHK("mode", ST_SLEEP, mode_o)
        `CHK("backup", 1'b0, backup_regulator_on_o)
        wm(ST_NO_POWER);
        test_done();
    end
endmodule // power_mode_sequencer_test
